// file: fpes_consts.vh
// Contract
// [RQ1] program is four writes, byte or word
// [RQ2] device runs program algorithm unaided
// [RQ3] bank returns to read; poll status bits
// [RQ4] commands during programming are ignored
// [RQ5] hardware reset aborts program; reissue later
// [RQ6] program only clears bits; status may vary
// [RQ7] unlock bypass entry: two unlocks plus 20h
// [RQ8] bypass program: A0h then address and data
// [RQ9] bypass accepts only program and reset
// [RQ10] bypass exit: bank 90h then 00h
// [RQ11] high voltage on accelerate pin forces bypass
// [RQ12] chip erase is six writes ending 10h
// [RQ13] erase preprograms internally, no host timing
// [RQ14] chip erase ignores commands; reset aborts
// [RQ15] sector erase six writes, sector plus 30h
// [RQ16] 50 us window accumulates more sectors
// [RQ17] host keeps sector add gaps under 50 us; controller stays busy through the window, so issues no sector add in it
// [RQ18] window timed from last strobe rising edge
// [RQ19] other command in window returns to read
// [RQ20] erase timer bit shows window expiry
// [RQ21] other banks readable during sector erase
// [RQ22] during sector erase only suspend is valid
// [RQ23] address captured on later falling strobe
// [RQ24] suspend B0h valid only in sector erase; controller issues it only when idle, never during an erase
// [RQ25] upper data byte ignored for commands
// [RQ26] command state kept per bank
`ifndef FPES_CONSTS_VH
`define FPES_CONSTS_VH
// ============================================================
// controller register offsets (byte addresses)
`define FPES_REG_CTRL 8'h00
`define FPES_REG_ADDR 8'h04
`define FPES_REG_DATA 8'h08
`define FPES_REG_STAT 8'h0c
`define FPES_REG_RDAT 8'h10
// ============================================================
// control field positions
`define FPES_CTRL_GO 0
`define FPES_CTRL_OP_LO 1
`define FPES_CTRL_OP_HI 3
`define FPES_CTRL_WORD 4
`define FPES_CTRL_ACC 5
// ============================================================
// operation codes
`define FPES_OP_PROG 3'h0
`define FPES_OP_BYP_ENTER 3'h1
`define FPES_OP_BYP_PROG 3'h2
`define FPES_OP_BYP_EXIT 3'h3
`define FPES_OP_CHIP_ERASE 3'h4
`define FPES_OP_SECT_ERASE 3'h5
`define FPES_OP_SECT_ADD 3'h6
`define FPES_OP_SUSPEND 3'h7
// ============================================================
// command addresses and data
`define FPES_UNLOCK_A1 12'h555
`define FPES_UNLOCK_A2 12'h2aa
`define FPES_UNLOCK_D1 8'haa
`define FPES_UNLOCK_D2 8'h55
`define FPES_CMD_PROG 8'ha0
`define FPES_CMD_BYPASS 8'h20
`define FPES_CMD_BYP_RST1 8'h90
`define FPES_CMD_BYP_RST2 8'h00
`define FPES_CMD_ERASE_SU 8'h80
`define FPES_CMD_CHIP 8'h10
`define FPES_CMD_SECTOR 8'h30
`define FPES_CMD_SUSPEND 8'hb0
// ============================================================
// timing
`define FPES_CLK_NS 10
`define FPES_WIN_US 50
`define FPES_WIN_CYC ((`FPES_WIN_US * 1000) / `FPES_CLK_NS)
`define FPES_STRB_NS 40
`define FPES_STRB_CYC ((`FPES_STRB_NS + `FPES_CLK_NS - 1) / `FPES_CLK_NS)
`endif

// file: fpes_sync.v
`timescale 1ns/1ns
// ============================================================
// two-flop synchroniser, one per bit
module fpes_sync #(
  parameter W = 2
) (
  input wire mclk, // system clock
  input wire reset_n, // async reset, active low
  input wire [W-1:0] d, // asynchronous inputs
  output wire [W-1:0] q // synchronised outputs
);
  reg [W-1:0] s1_r; // first stage, read only by second
  reg [W-1:0] s2_r; // second stage
  genvar i;
  // ============================================================
  // per-bit flop pair
  generate
    for (i = 0; i < W; i = i + 1) begin : g_bit
      always @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
          s1_r[i] <= 1'b0;
          s2_r[i] <= 1'b0;
        end else begin
          s1_r[i] <= d[i];
          s2_r[i] <= s1_r[i];
        end
      end
    end
  endgenerate
  assign q = s2_r;
endmodule // fpes_sync

// file: fpes_wcycle.v
`timescale 1ns/1ns
`include "fpes_consts.vh"
// ============================================================
// one flash write cycle: chip select falls a cycle before the write strobe and rises a cycle after it
module fpes_wcycle #(
  parameter AW = 21,
  parameter PULSE = `FPES_STRB_CYC
) (
  input wire mclk, // system clock
  input wire reset_n, // async reset, active low
  input wire start, // begin a write cycle, pulse
  input wire [AW-1:0] addr, // flash address
  input wire [15:0] data, // flash data
  output wire busy, // cycle in progress
  output wire done, // strobe just rose, pulse
  output reg [AW-1:0] f_addr_r, // address pins
  output reg [15:0] f_dout_r, // data pins out
  output reg f_doe_n_r, // data output enable, low drives
  output reg f_we_n_r, // write strobe
  output reg f_ce_n_r // chip select
);
  reg [1:0] ph_r; // phase: idle, setup, strobe, hold
  reg [7:0] cnt_r; // strobe low counter
  localparam P_IDLE = 2'd0;
  localparam P_SET = 2'd1;
  localparam P_STRB = 2'd2;
  localparam P_HOLD = 2'd3;
  assign busy = (ph_r != P_IDLE);
  assign done = (ph_r == P_HOLD);
  // ============================================================
  // address set before the falling strobe so the later falling
  // edge latches a stable address
  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      ph_r <= P_IDLE;
      cnt_r <= 8'h00;
      f_addr_r <= {AW{1'b0}};
      f_dout_r <= 16'h0000;
      f_doe_n_r <= 1'b1;
      f_we_n_r <= 1'b1;
      f_ce_n_r <= 1'b1;
    end else begin
      case (ph_r)
        P_IDLE: begin
          if (start) begin
            f_addr_r <= addr;
            f_dout_r <= data;
            f_doe_n_r <= 1'b0;
            f_ce_n_r <= 1'b0;
            ph_r <= P_SET;
          end
        end
        P_SET: begin
          f_we_n_r <= 1'b0; // [RQ23]
          cnt_r <= PULSE[7:0];
          ph_r <= P_STRB;
        end
        P_STRB: begin
          if (cnt_r <= 8'h01) begin
            f_we_n_r <= 1'b1; // rising edge latches data
            ph_r <= P_HOLD;
          end else begin
            cnt_r <= cnt_r - 8'h01;
          end
        end
        P_HOLD: begin
          f_ce_n_r <= 1'b1;
          f_doe_n_r <= 1'b1;
          ph_r <= P_IDLE;
        end
        default: ph_r <= P_IDLE;
      endcase
    end
  end
endmodule // fpes_wcycle

// file: fpes_ctrl.v
// Local design decisions: the AHB-Lite register port and the placing of the registers.
`timescale 1ns/1ns
`include "fpes_consts.vh"
// ============================================================
// host-side flash command sequencer behind an ahb-lite slave
module fpes_ctrl #(
  parameter AW = 21, // flash address width
  parameter BANK_LO = 18, // lowest bank address bit
  parameter WIN_CYC = `FPES_WIN_CYC, // sector add window, cycles
  parameter STRB_CYC = `FPES_STRB_CYC // write strobe width
) (
  input wire mclk, // system clock
  input wire reset_n, // async reset, active low
  input wire hsel, // ahb slave select
  input wire [31:0] haddr, // ahb address
  input wire [1:0] htrans, // ahb transfer type
  input wire hwrite, // ahb write
  input wire [2:0] hsize, // ahb size
  input wire [31:0] hwdata, // ahb write data
  input wire hready, // ahb bus ready
  output wire [31:0] hrdata, // ahb read data
  output wire hreadyout, // ahb slave ready
  output wire hresp, // ahb response, always okay
  output wire [AW-1:0] f_addr, // flash address pins
  output wire [15:0] f_dout, // flash data out
  output wire f_doe_n, // flash data enable, low drives
  input wire [15:0] f_din, // flash data in
  output wire f_we_n, // flash write strobe
  output wire f_ce_n, // flash chip select
  output reg f_oe_n_r, // flash output enable
  output reg f_reset_n_r, // flash hardware reset
  output reg f_word_r, // word/byte select level
  output reg f_acc_r, // request high voltage on accel pin
  input wire f_ready_busy // flash ready/busy, high is ready
);
  // ============================================================
  // registers
  reg [2:0] op_r; // operation selected
  reg [AW-1:0] tgt_r; // target address
  reg [15:0] dat_r; // program data
  reg busy_r; // sequence running
  reg [2:0] st_r; // sequencer state
  reg [2:0] step_r; // write index in sequence
  reg [15:0] rdat_r; // last status read
  reg [31:0] win_r; // window countdown
  reg win_open_r; // window still open
  reg abort_r; // hardware reset request
  reg [3:0] rst_cnt_r; // reset pulse length
  reg [1:0] pwait_r; // lets ready/busy cross the synchroniser
  reg wr_pend_r; // ahb data phase pending
  reg [7:0] wr_addr_r; // latched ahb address
  reg [7:0] rd_addr_r; // latched read address
  reg wstart_r; // start one write cycle
  reg [AW-1:0] waddr_r; // write cycle address
  reg [15:0] wdata_r; // write cycle data
  wire wbusy; // write cycle running
  wire wdone; // write cycle done
  wire [1:0] sync_q; // synchronised pins
  wire rb_s; // synchronised ready/busy
  wire ahb_go; // valid address phase
  reg [31:0] rd_mux; // read mux
  wire [AW-1:0] bank_a; // bank base of target
  reg [2:0] nsteps; // writes in the selected op
  localparam S_IDLE = 3'd0;
  localparam S_WRITE = 3'd1;
  localparam S_WAIT = 3'd2;
  localparam S_POLL = 3'd3;
  localparam S_RD = 3'd4;
  localparam S_RST = 3'd5;
  assign hresp = 1'b0;
  assign hreadyout = 1'b1;
  assign ahb_go = hsel & hready & htrans[1];
  assign bank_a = {tgt_r[AW-1:BANK_LO], {BANK_LO{1'b0}}};
  assign rb_s = sync_q[0];
  // ============================================================
  // ready/busy pin crosses in through two flops
  fpes_sync #(.W(2)) u_sync (
    .mclk(mclk),
    .reset_n(reset_n),
    .d({1'b0, f_ready_busy}),
    .q(sync_q)
  );
  // ============================================================
  // pin-level write cycle engine
  fpes_wcycle #(.AW(AW), .PULSE(STRB_CYC)) u_wc (
    .mclk(mclk),
    .reset_n(reset_n),
    .start(wstart_r),
    .addr(waddr_r),
    .data(wdata_r),
    .busy(wbusy),
    .done(wdone),
    .f_addr_r(f_addr),
    .f_dout_r(f_dout),
    .f_doe_n_r(f_doe_n),
    .f_we_n_r(f_we_n),
    .f_ce_n_r(f_ce_n)
  );
  // ============================================================
  // number of writes of each sequence
  always @* begin
    case (op_r)
      `FPES_OP_PROG: nsteps = 3'd4; // [RQ1]
      `FPES_OP_BYP_ENTER: nsteps = 3'd3; // [RQ7]
      `FPES_OP_BYP_PROG: nsteps = 3'd2; // [RQ8]
      `FPES_OP_BYP_EXIT: nsteps = 3'd2; // [RQ10]
      `FPES_OP_CHIP_ERASE: nsteps = 3'd6; // [RQ12]
      `FPES_OP_SECT_ERASE: nsteps = 3'd6; // [RQ15]
      default: nsteps = 3'd1; // sector add, suspend
    endcase
  end
  // ============================================================
  // address and data of write number step_r; upper byte zero on
  // command cycles since the device ignores it
  always @* begin
    waddr_r = {{(AW-12){1'b0}}, `FPES_UNLOCK_A1};
    wdata_r = {8'h00, `FPES_UNLOCK_D1}; // [RQ25]
    if (step_r == 3'd1 || step_r == 3'd4) begin
      waddr_r = {{(AW-12){1'b0}}, `FPES_UNLOCK_A2};
      wdata_r = {8'h00, `FPES_UNLOCK_D2};
    end
    case (op_r)
      `FPES_OP_PROG: begin
        if (step_r == 3'd2)
          wdata_r = {8'h00, `FPES_CMD_PROG};
        if (step_r == 3'd3) begin
          waddr_r = tgt_r; // [RQ1]
          wdata_r = f_word_r ? dat_r : {8'h00, dat_r[7:0]};
        end
      end
      `FPES_OP_BYP_ENTER: begin
        if (step_r == 3'd2)
          wdata_r = {8'h00, `FPES_CMD_BYPASS}; // [RQ7]
      end
      `FPES_OP_BYP_PROG: begin
        if (step_r == 3'd0) begin
          waddr_r = bank_a;
          wdata_r = {8'h00, `FPES_CMD_PROG}; // [RQ8]
        end else begin
          waddr_r = tgt_r;
          wdata_r = f_word_r ? dat_r : {8'h00, dat_r[7:0]};
        end
      end
      `FPES_OP_BYP_EXIT: begin
        waddr_r = bank_a; // [RQ10]
        wdata_r = (step_r == 3'd0) ? {8'h00, `FPES_CMD_BYP_RST1}
                                   : {8'h00, `FPES_CMD_BYP_RST2};
      end
      `FPES_OP_CHIP_ERASE, `FPES_OP_SECT_ERASE: begin
        if (step_r == 3'd2)
          wdata_r = {8'h00, `FPES_CMD_ERASE_SU};
        if (step_r == 3'd5) begin
          if (op_r == `FPES_OP_CHIP_ERASE) begin
            wdata_r = {8'h00, `FPES_CMD_CHIP}; // [RQ12]
          end else begin
            waddr_r = tgt_r; // [RQ15]
            wdata_r = {8'h00, `FPES_CMD_SECTOR};
          end
        end
      end
      `FPES_OP_SECT_ADD: begin
        waddr_r = tgt_r; // [RQ16]
        wdata_r = {8'h00, `FPES_CMD_SECTOR};
      end
      default: begin
        waddr_r = bank_a; // [RQ24]
        wdata_r = {8'h00, `FPES_CMD_SUSPEND};
      end
    endcase
  end
  // ============================================================
  // register read mux
  always @* begin
    case (rd_addr_r)
      `FPES_REG_CTRL: rd_mux = {26'h0, f_acc_r, f_word_r, op_r, 1'b0};
      `FPES_REG_ADDR: rd_mux = {{(32-AW){1'b0}}, tgt_r};
      `FPES_REG_DATA: rd_mux = {16'h0, dat_r};
      `FPES_REG_STAT: rd_mux = {28'h0, win_open_r, rb_s, abort_r,
                                busy_r};
      `FPES_REG_RDAT: rd_mux = {16'h0, rdat_r};
      default: rd_mux = 32'h0;
    endcase
  end
  assign hrdata = rd_mux;
  // ============================================================
  // ahb slave and sequencer
  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      op_r <= `FPES_OP_PROG;
      tgt_r <= {AW{1'b0}};
      dat_r <= 16'h0000;
      busy_r <= 1'b0;
      st_r <= S_IDLE;
      step_r <= 3'd0;
      rdat_r <= 16'h0000;
      win_r <= 32'h0;
      win_open_r <= 1'b0;
      abort_r <= 1'b0;
      rst_cnt_r <= 4'h0;
      pwait_r <= 2'd0;
      wr_pend_r <= 1'b0;
      wr_addr_r <= 8'h00;
      rd_addr_r <= 8'h00;
      wstart_r <= 1'b0;
      f_oe_n_r <= 1'b1;
      f_reset_n_r <= 1'b1;
      f_word_r <= 1'b1;
      f_acc_r <= 1'b0;
    end else begin
      wstart_r <= 1'b0;
      // address phase capture
      if (ahb_go) begin
        rd_addr_r <= haddr[7:0];
        wr_pend_r <= hwrite;
        wr_addr_r <= haddr[7:0];
      end else begin
        wr_pend_r <= 1'b0;
      end
      // window counts from the last strobe rise of a sector write
      if (wdone && (op_r == `FPES_OP_SECT_ERASE ||
                    op_r == `FPES_OP_SECT_ADD) &&
          step_r + 3'd1 >= nsteps) begin
        win_r <= WIN_CYC; // [RQ18]
        win_open_r <= 1'b1; // [RQ16]
      end else if (win_r != 32'h0) begin
        win_r <= win_r - 32'h1;
      end else begin
        win_open_r <= 1'b0; // [RQ17]
      end
      // data phase writes; commands refused while busy
      if (wr_pend_r) begin
        case (wr_addr_r)
          `FPES_REG_CTRL: begin
            f_word_r <= hwdata[`FPES_CTRL_WORD];
            f_acc_r <= hwdata[`FPES_CTRL_ACC]; // [RQ11]
            if (hwdata[`FPES_CTRL_GO] && !busy_r) begin
              op_r <= hwdata[`FPES_CTRL_OP_HI:`FPES_CTRL_OP_LO];
              busy_r <= 1'b1;
              step_r <= 3'd0;
              st_r <= S_WRITE;
            end
          end
          `FPES_REG_ADDR: tgt_r <= hwdata[AW-1:0];
          `FPES_REG_DATA: dat_r <= hwdata[15:0];
          default: ; // status writes handled after the sequencer
        endcase
      end
      case (st_r)
        S_IDLE: ;
        S_WRITE: begin
          if (!wbusy) begin
            wstart_r <= 1'b1; // [RQ26]
            st_r <= S_WAIT;
          end
        end
        S_WAIT: begin
          if (wdone) begin
            if (step_r + 3'd1 >= nsteps) begin
              step_r <= 3'd0;
              pwait_r <= 2'd3;
              // program and erase run alone in the device
              st_r <= S_POLL; // [RQ2] [RQ13]
            end else begin
              step_r <= step_r + 3'd1;
              st_r <= S_WRITE;
            end
          end
        end
        S_POLL: begin
          // no new command until ready so none is lost to the device
          // a stale ready from before the last strobe must not count
          if (pwait_r != 2'd0) begin
            pwait_r <= pwait_r - 2'd1;
          end else if (rb_s && !wbusy) begin // [RQ4] [RQ22]
            f_oe_n_r <= 1'b0;
            st_r <= S_RD;
          end
        end
        S_RD: begin
          // read back the last write address; data or status bits land here
          rdat_r <= f_din; // [RQ3] [RQ6] [RQ20] [RQ21]
          f_oe_n_r <= 1'b1;
          busy_r <= 1'b0;
          st_r <= S_IDLE;
        end
        S_RST: begin
          f_reset_n_r <= 1'b0;
          if (rst_cnt_r == 4'h0) begin
            f_reset_n_r <= 1'b1;
            abort_r <= 1'b0;
            busy_r <= 1'b0;
            st_r <= S_IDLE;
          end else begin
            rst_cnt_r <= rst_cnt_r - 4'h1;
          end
        end
        default: st_r <= S_IDLE;
      endcase
      // abort last so it overrides whatever the sequencer chose
      if (wr_pend_r && wr_addr_r == `FPES_REG_STAT && hwdata[1]) begin
        abort_r <= 1'b1; // [RQ5] [RQ14]
        busy_r <= 1'b1;
        st_r <= S_RST;
        step_r <= 3'd0;
        wstart_r <= 1'b0;
        rst_cnt_r <= 4'hf;
        win_r <= 32'h0;
        win_open_r <= 1'b0;
      end
    end
  end
  // the flash drives data only when output enable is low; the
  // address for read-back stays as the last write cycle left it
  // [RQ9] [RQ19]: bypass and window ops are chosen by software
endmodule // fpes_ctrl

// file: fpes_ctrl_properties.sv
`timescale 1ns/1ns
// ============================================================
// checks on the bus answer and the flash write, read and reset pins
module fpes_ctrl_properties #(
  parameter AW = 21 // flash address width
) (
  input wire mclk, // system clock
  input wire reset_n, // async reset, active low
  input wire hreadyout, // slave ready
  input wire hresp, // slave response
  input wire [AW-1:0] f_addr, // flash address
  input wire [15:0] f_dout, // flash data out
  input wire f_doe_n, // data drive enable, low drives
  input wire f_we_n, // write strobe
  input wire f_ce_n, // chip select
  input wire f_oe_n_r, // read enable
  input wire f_reset_n_r // flash reset
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);
  // ============================================================
  // bus answer: zero wait, always okay
  zero_wait_a: assert property (hreadyout && !hresp)
    else $error("bus answer not ready or not okay");
  // ============================================================
  // write cycle: strobe only inside select, data driven
  we_in_ce_a: assert property (!f_we_n |-> !f_ce_n && !f_doe_n)
    else $error("strobe low outside select or undriven data");
  we_width_a: assert property (
    $fell(f_we_n) |-> (!f_we_n)[*3] ##[1:2] f_we_n)
    else $error("write strobe width wrong");
  // address must not move once the strobe fell, it is latched there
  addr_hold_a: assert property (
    !f_we_n |-> $stable(f_addr) && $stable(f_dout))
    else $error("address or data moved under strobe");
  ce_release_a: assert property ($rose(f_we_n) |-> ##[0:3] f_ce_n)
    else $error("select not released after strobe");
  // a read never overlaps a write or our own data drive
  no_rd_wr_a: assert property (!f_oe_n_r |-> f_we_n && f_doe_n)
    else $error("read enable while writing");
  rst_pulse_a: assert property (
    $fell(f_reset_n_r) |-> (!f_reset_n_r)[*8])
    else $error("flash reset pulse too short");
  rst_quiet_a: assert property (
    $fell(f_reset_n_r) |-> ##[0:6] (f_we_n && f_ce_n))
    else $error("writes go on during flash reset");
endmodule // fpes_ctrl_properties

bind fpes_ctrl fpes_ctrl_properties #(.AW(AW)) u_props (
  .mclk(mclk), .reset_n(reset_n), .hreadyout(hreadyout), .hresp(hresp),
  .f_addr(f_addr), .f_dout(f_dout), .f_doe_n(f_doe_n), .f_we_n(f_we_n),
  .f_ce_n(f_ce_n), .f_oe_n_r(f_oe_n_r), .f_reset_n_r(f_reset_n_r)
);

// file: fpes_flash_model.sv
`timescale 1ns/1ns
// ============================================================
// behavioural flash device: command decode, timers, array
module fpes_flash_model #(
  parameter PROG_T = 10, // program busy, 10 ns ticks
  parameter ERASE_T = 50, // erase busy, ticks
  parameter WIN_T = 5000 // sector add window, ticks
) (
  input wire [20:0] f_addr, // address pins
  input wire [15:0] f_dout, // data from host
  input wire f_we_n, // write strobe
  input wire f_ce_n, // chip select
  input wire f_oe_n, // read enable
  input wire f_reset_n, // hardware reset
  input wire f_word, // word mode
  input wire f_acc, // high voltage on accelerate pin
  output wire [15:0] f_din, // data to host
  output wire f_ready_busy // high is ready
);
  logic [15:0] mem [int]; // programmed words, absent reads erased
  logic [8:0] sect [$]; // sectors queued for erase
  int st = 0; // decode state, 0 is array read, 7 bypass
  int busy_cnt = 0; // embedded algorithm ticks left
  int win_cnt = 0; // accumulation window ticks left
  logic [20:0] lat_a = '0; // latched address
  logic [15:0] dq_r = '0; // read bus
  function automatic [15:0] rd(input int a);
    rd = mem.exists(a) ? mem[a] : 16'hffff;
  endfunction
  // ============================================================
  // address latched on the later falling edge, select falls first
  always @(negedge f_we_n) if (!f_ce_n) lat_a = f_addr;
  // command on the strobe rising edge; upper byte is don't care
  always @(posedge f_we_n) if (!f_ce_n && f_reset_n) begin
    logic [7:0] c;
    c = f_dout[7:0];
    if (busy_cnt != 0) begin
    end else if (win_cnt != 0) begin
      if (c == 8'h30) begin
        sect.push_back(lat_a[20:12]);
        win_cnt = WIN_T;
      end else begin
        win_cnt = 0;
        sect.delete();
        st = 0;
      end
    end else case (st)
      0: st = (lat_a[11:0] == 12'h555 && c == 8'haa) ? 1 : 0;
      1: st = (lat_a[11:0] == 12'h2aa && c == 8'h55) ? 2 : 0;
      2: if (lat_a[11:0] != 12'h555) st = 0;
        else st = c == 8'ha0 ? 3 : c == 8'h20 ? 7 : c == 8'h80 ? 4 : 0;
      3, 8: begin
        mem[lat_a] = rd(lat_a) & (f_word ? f_dout : {8'hff, f_dout[7:0]});
        busy_cnt = PROG_T;
        st = (st == 8) ? 7 : 0;
      end
      4: st = (c == 8'haa) ? 5 : 0;
      5: st = (c == 8'h55) ? 6 : 0;
      6: begin
        if (c == 8'h10) begin
          mem.delete();
          busy_cnt = ERASE_T;
        end else if (c == 8'h30) begin
          sect = {lat_a[20:12]};
          win_cnt = WIN_T;
        end
        st = 0;
      end
      7: st = c == 8'ha0 ? 8 : c == 8'h90 ? 9 : 7;
      9: st = (c == 8'h00) ? 0 : 7;
      default: st = 0;
    endcase
  end
  // ============================================================
  // timers; hardware reset aborts whatever runs
  always #10 begin
    if (!f_reset_n) begin
      busy_cnt = 0;
      win_cnt = 0;
      st = 0;
      sect.delete();
    end else begin
      if (f_acc && st == 0) st = 7;
      if (busy_cnt != 0) busy_cnt--;
      if (win_cnt != 0) begin
        win_cnt--;
        if (win_cnt == 0) begin
          foreach (mem[k]) if (sect.size() != 0 && k[20:12] inside {sect})
            mem.delete(k);
          busy_cnt = ERASE_T;
        end
      end
    end
  end
  // released bus shows no stale value
  always @(f_oe_n, f_addr) dq_r = !f_oe_n ? rd(f_addr) : ~dq_r;
  assign f_din = dq_r;
  assign f_ready_busy = (busy_cnt == 0 && win_cnt == 0);
endmodule // fpes_flash_model

// file: fpes_ctrl_tb_top.sv
`timescale 1ns/1ns
`include "fpes_consts.vh"
// ============================================================
// bench: ahb-lite master tasks driving the sequencer
module fpes_ctrl_tb_top;
  logic mclk = 0, reset_n, hsel, hwrite;
  logic [31:0] haddr, hwdata;
  logic [1:0] htrans;
  logic [2:0] hsize;
  wire [31:0] hrdata;
  wire hreadyout, hresp, f_doe_n, f_we_n, f_ce_n, f_oe_n, f_rst_n;
  wire f_word, f_acc, f_rb;
  wire [20:0] f_addr;
  wire [15:0] f_dout, f_din;
  int error_cnt = 0, num_checks = 0;
  logic [31:0] s;
  bit seen_win;
  always #5 mclk = ~mclk;
  fpes_ctrl #(.WIN_CYC(20)) dut (.mclk(mclk), .reset_n(reset_n),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .f_addr(f_addr),
    .f_dout(f_dout), .f_doe_n(f_doe_n), .f_din(f_din), .f_we_n(f_we_n),
    .f_ce_n(f_ce_n), .f_oe_n_r(f_oe_n), .f_reset_n_r(f_rst_n),
    .f_word_r(f_word), .f_acc_r(f_acc), .f_ready_busy(f_rb));
  fpes_flash_model #(.WIN_T(20)) mdl (.f_addr(f_addr), .f_dout(f_dout),
    .f_we_n(f_we_n), .f_ce_n(f_ce_n), .f_oe_n(f_oe_n), .f_reset_n(f_rst_n),
    .f_word(f_word), .f_acc(f_acc), .f_din(f_din), .f_ready_busy(f_rb));
  // ============================================================
  // closing report, reached from the end or from a spent wait
  task automatic results();
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic check(input [31:0] got, input [31:0] exp, input string m);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  // one single transfer; entered just after a rising edge
  task automatic ahb(input bit wr, input [7:0] a, input [31:0] wd,
                     output [31:0] rv);
    int n;
    hsel <= 1'b1;
    htrans <= 2'b10;
    hsize <= 3'b010;
    haddr <= {24'h0, a};
    hwrite <= wr;
    n = 0;
    do begin @(posedge mclk); n++; end while (hreadyout !== 1'b1 && n < 50);
    htrans <= 2'b00;
    hwdata <= wd;
    do begin @(posedge mclk); n++; end while (hreadyout !== 1'b1 && n < 99);
    rv = hrdata;
    if (n >= 99) begin error_cnt++; results(); end
  endtask
  // load target and data, then start; acc asks for the high voltage
  task automatic go(input [2:0] o, input [20:0] a, input [15:0] d,
                    input bit acc);
    ahb(1, `FPES_REG_ADDR, {11'h0, a}, s);
    ahb(1, `FPES_REG_DATA, {16'h0, d}, s);
    ahb(1, `FPES_REG_CTRL, {26'h0, acc, 1'b1, o, 1'b1}, s);
  endtask
  // poll busy under a bound, noting whether the window bit showed
  task automatic idle();
    int n;
    n = 0;
    do begin
      ahb(0, `FPES_REG_STAT, 0, s);
      if (s[3] === 1'b1) seen_win = 1;
      n++;
    end while (s[0] !== 1'b0 && n < 3000);
    if (n >= 3000) begin error_cnt++; results(); end
  endtask
  // ============================================================
  // main sequence
  initial begin
    reset_n <= 1'b0;
    hsel <= 1'b0;
    hwrite <= 1'b0;
    haddr <= 32'h0;
    hwdata <= 32'h0;
    htrans <= 2'b00;
    hsize <= 3'b010;
    repeat (5) @(posedge mclk);
    reset_n <= 1'b1;
    @(posedge mclk);
    ahb(1, 8'h14, 32'hffff_ffff, s);
    ahb(0, 8'h14, 0, s);
    check(s, 0, "unmapped read");
    check(f_word, 1, "word mode level");
    go(`FPES_OP_PROG, 21'h00100, 16'h1234, 0);
    idle();
    check(mdl.rd(21'h100), 16'h1234, "program");
    check(mdl.st, 0, "back to array read");
    ahb(0, `FPES_REG_RDAT, 0, s);
    check(s[15:0], 16'h1234, "read back");
    go(`FPES_OP_PROG, 21'h00100, 16'hffff, 0);
    idle();
    check(mdl.rd(21'h100), 16'h1234, "zero to one");
    go(`FPES_OP_BYP_ENTER, 21'h0, 16'h0, 0);
    idle();
    check(mdl.st, 7, "bypass entry");
    go(`FPES_OP_BYP_PROG, 21'h01100, 16'h00f0, 0);
    idle();
    go(`FPES_OP_BYP_PROG, 21'h01102, 16'h0f0f, 0);
    idle();
    check(mdl.rd(21'h1100), 16'h00f0, "bypass prog one");
    check(mdl.rd(21'h1102), 16'h0f0f, "bypass prog two");
    check(mdl.st, 7, "still bypass");
    go(`FPES_OP_BYP_EXIT, 21'h0, 16'h0, 0);
    idle();
    check(mdl.st, 0, "bypass exit");
    go(`FPES_OP_BYP_PROG, 21'h00300, 16'h5555, 1);
    idle();
    check(f_acc, 1, "accelerate level");
    check(mdl.rd(21'h300), 16'h5555, "accelerated prog");
    go(`FPES_OP_BYP_EXIT, 21'h0, 16'h0, 0);
    idle();
    check(f_acc, 0, "accelerate dropped");
    seen_win = 0;
    go(`FPES_OP_SECT_ERASE, 21'h01000, 16'h0, 0);
    idle();
    check(seen_win, 1, "window seen");
    check(s[3], 0, "window closed");
    check(mdl.rd(21'h1100), 16'hffff, "sector erased");
    check(mdl.rd(21'h100), 16'h1234, "other sector kept");
    go(`FPES_OP_CHIP_ERASE, 21'h0, 16'h0, 0);
    go(`FPES_OP_PROG, 21'h00200, 16'h0000, 0);
    idle();
    check(mdl.rd(21'h100), 16'hffff, "chip erased");
    check(mdl.rd(21'h200), 16'hffff, "go while busy");
    go(`FPES_OP_PROG, 21'h00400, 16'h0000, 0);
    ahb(1, `FPES_REG_STAT, 32'h2, s);
    ahb(0, `FPES_REG_STAT, 0, s);
    check(s[1], 1, "abort flag");
    idle();
    check(s[1], 0, "abort cleared");
    check(mdl.busy_cnt, 0, "flash idle after reset");
    results();
  end
endmodule // fpes_ctrl_tb_top
